// File: src/dma_queue_pkg.sv
// Constants, field layouts and types shared by the DMA queue control block
package dma_queue_pkg;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_IN_LIMITS   = 8'h88;
	localparam logic [7:0] OFS_DMA_SETUP   = 8'h90;
	localparam logic [7:0] OFS_FLAG_STYLE  = 8'h94;
	localparam logic [7:0] OFS_QUEUE_DEBUG = 8'h98;
	localparam logic [7:0] OFS_OP_DEBUG    = 8'h9c;
	localparam logic [7:0] OFS_IRQ_STATUS  = 8'ha0;
	localparam logic [7:0] OFS_IRQ_MASK    = 8'ha4;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [31:0] DMA_SETUP_RST  = 32'h0000_0701;
	localparam logic [31:0] FLAG_STYLE_RST = 32'h2040_0000;
	localparam logic [7:0]  IN_LIMIT_RST   = 8'h3c;
	localparam logic [7:0]  OP_CODE_RST    = 8'hff;
	localparam logic [23:0] OP_ARG_RST     = 24'h00_0000;
	localparam logic [7:0]  LOAD_RST       = 8'h00;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int IN_CMD_LOAD_LSB = 16;
	localparam int OUT_LOAD_LSB    = 8;
	localparam int IN_LOAD_LSB     = 0;
	localparam int OP_ARG_LSB      = 8;
	localparam int IRQ_SEQ_END     = 0;
	localparam int IRQ_SEQ_START   = 1;
	localparam int IRQ_W           = 2;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic [18:0] unused_hi;
		logic [4:0]  stop_pulse_length;
		logic [2:0]  unused_lo;
		logic        open_drain;
		logic        polarity_flip;
		logic        demand_mode;
		logic        enable;
		logic        to_input;
	} dma_setup_t;

	typedef struct packed {
		logic o;
		logic oe;
	} pin_t;

	typedef enum {ST_IDLE, ST_XFER, ST_STOP} seq_state_t;

endpackage : dma_queue_pkg

// File: src/pin_drive.sv
// Output pin driver with polarity flip and open-drain option
module pin_drive
	import dma_queue_pkg::*;
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Control
	input  wire logic level_i,
	input  wire logic flip_i,
	input  wire logic open_drain_i,
	// Pin
	output pin_t      pin_o
);

	logic v;

	assign v = level_i ^ flip_i;

	// ----------------------------------------
	// Registered pin drive
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pin_o <= '{o: 1'b0, oe: 1'b1};
		end
		else if (open_drain_i)
		begin
			pin_o <= '{o: 1'b0, oe: ~v};
		end
		else
		begin
			pin_o <= '{o: v, oe: 1'b1};
		end
	end

endmodule : pin_drive

// File: src/stop_pulse_timer.sv
// Down counter that times the DMA stop pulse
module stop_pulse_timer
	import dma_queue_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Control
	input  wire logic       start_i,
	input  wire logic [4:0] len_i,
	// Status
	output logic            busy_o,
	output logic            done_o
);

	logic [4:0] cnt_q;

	assign busy_o = (cnt_q != 5'h00);
	assign done_o = (cnt_q == 5'h01);

	// ----------------------------------------
	// Counter, never shorter than one cycle
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cnt_q <= 5'h00;
		else if (start_i)
			cnt_q <= (len_i == 5'h00) ? 5'h01 : len_i;
		else if (busy_o)
			cnt_q <= cnt_q - 5'h01;
	end

endmodule : stop_pulse_timer

// File: src/host_dma_queue_control.sv
// DMA setup, flow-control pins and queue debug views of the host bus interface
// What this block does
// - Stop pulse length is a 5-bit field, reset value 7
// - Larger variant: open-drain bit makes request, stop, interrupt outputs open-drain
// - Larger variant: polarity bit inverts request, stop and interrupt outputs together
// - Handshake only while enabled; mode bit picks demand or block transfer style
// - Direction bit picks input queue (1) or output queue (0); resets to 1
// - 32-bit flag style register, each bit dynamic or static, reset 0x20400000
// - Read-only 8-bit input load of current command, reset zero
// - Read-only total input load, 8 or 7 bits by variant, reset zero
// - Read-only output load, 8 or 7 bits; loads sampled unsynchronised
// - Smaller variant: read-only 24-bit argument of running operation, reset zero
// - Smaller variant: read-only 8-bit code of running operation, reset all ones
// - Programmable lower input-load limit governs DMA into input queue, reset 0x3C
//
// The implementer's own choice: the Wishbone slave port.
module host_dma_queue_control
	import dma_queue_pkg::*;
#(
	parameter bit IS_LARGE = 1'b1
)
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// Core side
	input  wire logic [7:0]  in_load_i,
	input  wire logic [7:0]  in_cmd_load_i,
	input  wire logic [7:0]  out_load_i,
	input  wire logic [7:0]  op_code_i,
	input  wire logic [23:0] op_arg_i,
	output logic      [31:0] flag_style_o,
	// DMA pins
	input  wire logic        dma_ack_i,
	output pin_t             dma_request_out_o,
	output pin_t             dma_stop_out_o,
	output pin_t             irq_out_o,
	// Interrupt
	output logic             irq_o
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a[7:2] == ofs[7:2]);
	endfunction : hit

	function automatic logic [7:0] load_mask(input logic [7:0] v);
		load_mask = IS_LARGE ? v : {1'b0, v[6:0]};
	endfunction : load_mask

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		merge = old;
		for (int i = 0; i < 4; i++)
			if (sel[i])
				merge[i*8 +: 8] = nw[i*8 +: 8];
	endfunction : merge

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	dma_setup_t       setup_q;
	logic [31:0]      flag_style_q;
	logic [7:0]       in_limit_q;
	logic [IRQ_W-1:0] irq_st_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [7:0]       in_load_q;
	logic [7:0]       in_cmd_load_q;
	logic [7:0]       out_load_q;
	logic [7:0]       op_code_q;
	logic [23:0]      op_arg_q;
	logic             ack_s1_q;
	logic             ack_s2_q;
	logic             ack_s3_q;
	logic             dreq_q;
	seq_state_t       state_q;
	logic             req;
	logic             wr;
	logic             want;
	logic             timer_start;
	logic             stop_busy;
	logic             stop_done;
	logic [IRQ_W-1:0] irq_ev;
	logic             flip;
	logic             od;
	logic             irq_level;

	assign req          = cyc_i & stb_i & ~ack_o;
	assign wr           = req & we_i;
	assign flag_style_o = flag_style_q;
	assign flip         = IS_LARGE & setup_q.polarity_flip;
	assign od           = IS_LARGE & setup_q.open_drain;
	assign irq_level    = |(irq_st_q & irq_mask_q);

	// ----------------------------------------
	// Bus writes
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			setup_q      <= DMA_SETUP_RST;
			flag_style_q <= FLAG_STYLE_RST;
			in_limit_q   <= IN_LIMIT_RST;
			irq_mask_q   <= '0;
		end
		else if (wr)
		begin
			if (hit(adr_i, OFS_DMA_SETUP))
				setup_q <= merge(setup_q, dat_i, sel_i);
			if (hit(adr_i, OFS_FLAG_STYLE))
				flag_style_q <= merge(flag_style_q, dat_i, sel_i);
			if (hit(adr_i, OFS_IN_LIMITS) && sel_i[0])
				in_limit_q <= load_mask(dat_i[7:0]);
			if (hit(adr_i, OFS_IRQ_MASK) && sel_i[0])
				irq_mask_q <= dat_i[IRQ_W-1:0];
		end
	end

	// ----------------------------------------
	// Bus answer
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= '0;
		end
		else
		begin
			ack_o <= req;
			dat_o <= '0;
			if (req && !we_i)
			begin
				case (1'b1)
					hit(adr_i, OFS_DMA_SETUP):  dat_o <= setup_q;
					hit(adr_i, OFS_FLAG_STYLE): dat_o <= flag_style_q;
					hit(adr_i, OFS_IN_LIMITS):  dat_o <= {24'h00_0000, in_limit_q};
					hit(adr_i, OFS_QUEUE_DEBUG):
						dat_o <= {8'h00, in_cmd_load_q, out_load_q, in_load_q};
					hit(adr_i, OFS_OP_DEBUG):
						dat_o <= IS_LARGE ? 32'h0000_0000 : {op_arg_q, op_code_q};
					hit(adr_i, OFS_IRQ_STATUS): dat_o <= {{(32-IRQ_W){1'b0}}, irq_st_q};
					hit(adr_i, OFS_IRQ_MASK):   dat_o <= {{(32-IRQ_W){1'b0}}, irq_mask_q};
					default:                    dat_o <= '0;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Core state samples
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			in_load_q     <= LOAD_RST;
			in_cmd_load_q <= LOAD_RST;
			out_load_q    <= LOAD_RST;
			op_code_q     <= OP_CODE_RST;
			op_arg_q      <= OP_ARG_RST;
		end
		else
		begin
			in_load_q     <= load_mask(in_load_i);
			in_cmd_load_q <= in_cmd_load_i;
			out_load_q    <= load_mask(out_load_i);
			op_code_q     <= op_code_i;
			op_arg_q      <= op_arg_i;
		end
	end

	// ----------------------------------------
	// Acknowledge pin synchroniser
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
			ack_s3_q <= 1'b0;
		end
		else
		begin
			ack_s1_q <= dma_ack_i;
			ack_s2_q <= ack_s1_q;
			ack_s3_q <= ack_s2_q;
		end
	end

	// ----------------------------------------
	// Transfer sequence
	// ----------------------------------------
	assign want = setup_q.enable & (setup_q.to_input ? (in_load_q < in_limit_q) : (out_load_q != LOAD_RST));
	assign timer_start = (state_q == ST_XFER) && !want;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state_q <= ST_IDLE;
		else
		begin
			case (state_q)
				ST_IDLE:
					if (want)
						state_q <= ST_XFER;
				ST_XFER:
					if (!want)
						state_q <= ST_STOP;
				ST_STOP:
					if (stop_done)
						state_q <= ST_IDLE;
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// Demand mode follows the sequence; block mode holds until acknowledged
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dreq_q <= 1'b0;
		else if (state_q == ST_IDLE && want)
			dreq_q <= 1'b1;
		else if (state_q != ST_XFER || !want)
			dreq_q <= 1'b0;
		else if (!setup_q.demand_mode && ack_s2_q && !ack_s3_q)
			dreq_q <= 1'b0;
	end

	stop_pulse_timer u_timer (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.start_i (timer_start),
		.len_i   (setup_q.stop_pulse_length),
		.busy_o  (stop_busy),
		.done_o  (stop_done)
	);

	// ----------------------------------------
	// Interrupt status and output
	// ----------------------------------------
	assign irq_ev[IRQ_SEQ_END]   = timer_start;
	assign irq_ev[IRQ_SEQ_START] = (state_q == ST_IDLE) && want;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_st_q <= '0;
		else if (wr && hit(adr_i, OFS_IRQ_STATUS) && sel_i[0])
			irq_st_q <= (irq_st_q & ~dat_i[IRQ_W-1:0]) | irq_ev;
		else
			irq_st_q <= irq_st_q | irq_ev;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= irq_level;
	end

	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	pin_drive u_dreq (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.level_i      (dreq_q),
		.flip_i       (flip),
		.open_drain_i (od),
		.pin_o        (dma_request_out_o)
	);

	pin_drive u_stop_pulse_length (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.level_i      (stop_busy),
		.flip_i       (flip),
		.open_drain_i (od),
		.pin_o        (dma_stop_out_o)
	);

	pin_drive u_irq (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.level_i      (irq_level),
		.flip_i       (flip),
		.open_drain_i (od),
		.pin_o        (irq_out_o)
	);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	logic [5:0] busy_run_q;

	always_ff @(posedge clk_i)
	begin
		if (rst_i || !stop_busy)
			busy_run_q <= '0;
		else
			busy_run_q <= busy_run_q + 6'h01;
	end

	property p_stop_reset;
		@(posedge clk_i) rst_i |=> setup_q.stop_pulse_length == 5'h07;
	endproperty
	a_stop_reset: assert property (p_stop_reset) else $error("stop length reset wrong");

	property p_open_drain;
		@(posedge clk_i) disable iff (rst_i) od |=> dma_stop_out_o.o == 1'b0 && irq_out_o.o == 1'b0;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("open drain pin driven high");

	property p_polarity;
		@(posedge clk_i) disable iff (rst_i) !od |=> dma_stop_out_o.o == ($past(stop_busy) ^ $past(flip));
	endproperty
	a_polarity: assert property (p_polarity) else $error("stop pin polarity wrong");

	property p_enable;
		@(posedge clk_i) disable iff (rst_i) (!setup_q.enable && state_q == ST_IDLE) |=> !dreq_q;
	endproperty
	a_enable: assert property (p_enable) else $error("request while disabled");

	property p_dir_reset;
		@(posedge clk_i) rst_i |=> setup_q.to_input && !setup_q.enable;
	endproperty
	a_dir_reset: assert property (p_dir_reset) else $error("direction reset wrong");

	property p_flag_reset;
		@(posedge clk_i) rst_i |=> flag_style_o == FLAG_STYLE_RST;
	endproperty
	a_flag_reset: assert property (p_flag_reset) else $error("flag style reset wrong");

	property p_queue_read;
		@(posedge clk_i) disable iff (rst_i)
			(req && !we_i && hit(adr_i, OFS_QUEUE_DEBUG)) ##1 1'b1
			|-> ack_o && dat_o[23:16] == $past(in_cmd_load_q) && dat_o[15:8] == $past(out_load_q);
	endproperty
	a_queue_read: assert property (p_queue_read) else $error("queue debug read wrong");

	property p_op_reset;
		@(posedge clk_i) rst_i |=> op_code_q == OP_CODE_RST && op_arg_q == OP_ARG_RST;
	endproperty
	a_op_reset: assert property (p_op_reset) else $error("operation debug reset wrong");

	property p_pulse_len;
		@(posedge clk_i) disable iff (rst_i)
			$fell(stop_busy) |-> $past(busy_run_q) + 6'h01
				== (($past(setup_q.stop_pulse_length) == 5'h00) ? 6'h01 : {1'b0, $past(setup_q.stop_pulse_length)});
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("stop pulse length wrong");

	property p_limit_reset;
		@(posedge clk_i) rst_i |=> in_limit_q == IN_LIMIT_RST;
	endproperty
	a_limit_reset: assert property (p_limit_reset) else $error("input limit reset wrong");

endmodule : host_dma_queue_control

// File: verif/dma_host_model.sv
// Host DMA controller model that acknowledges requests
module dma_host_model
#(
	parameter int DELAY = 4
)
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// DMA pins
	input  wire logic req_i,
	output logic      ack_o
);
	timeunit 1ns;
	timeprecision 1ns;

	int cnt;

	// ----
	// Acknowledge after DELAY cycles of request, drop with it
	// ----
	always @(posedge clk_i)
	begin
		if (rst_i || !req_i)
		begin
			cnt <= 0;
			ack_o <= 1'b0;
		end
		else
		begin
			if (cnt < DELAY)
				cnt <= cnt + 1;
			ack_o <= (cnt >= DELAY);
		end
	end
endmodule : dma_host_model

// File: verif/testbench.sv
// Bench for the DMA queue control block
module testbench
	import dma_queue_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack_o, irq_o, dma_ack;
	logic [7:0]  adr = 0, in_load = 0, cmd_load = 0, out_load = 0, op_code = 0;
	logic [3:0]  sel = 0;
	logic [23:0] op_arg = 0;
	logic [31:0] dat = 0, dat_o, flag_style_o, q;
	pin_t        req_p, stp_p, irq_p;
	wire         req_w = req_p.oe ? req_p.o : 1'b1;
	wire         stp_w = stp_p.oe ? stp_p.o : 1'b1;
	wire         irq_w = irq_p.oe ? irq_p.o : 1'b1;
	int          miscompares = 0, n_compared = 0;
	int          lens[2] = '{7, 31};

	always #50 clk_i = ~clk_i;

	host_dma_queue_control i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .in_load_i(in_load),
		.in_cmd_load_i(cmd_load), .out_load_i(out_load), .op_code_i(op_code), .op_arg_i(op_arg),
		.flag_style_o(flag_style_o), .dma_ack_i(dma_ack), .dma_request_out_o(req_p),
		.dma_stop_out_o(stp_p), .irq_out_o(irq_p), .irq_o(irq_o));

	dma_host_model i_host (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_w), .ack_o(dma_ack));

	// ----
	// Tasks
	// ----
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_o !== 1'b1 && n < 50);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 50)
			miscompares++;
	endtask : wb

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(q, e);
	endtask : rd

	task automatic wait_req(input logic v);
		int n;
		n = 0;
		while (req_w !== v && n < 30)
		begin
			@(posedge clk_i);
			n++;
		end
		chk(32'(req_w), 32'(v));
	endtask : wait_req

	task automatic count_stop(input int len);
		int c;
		c = 0;
		repeat (45)
		begin
			@(posedge clk_i);
			if (stp_w === 1'b1)
				c++;
		end
		chk(32'(c), 32'(len));
	endtask : count_stop

	task automatic stop_test();
		$display("Compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	// ----
	// Tests
	// ----
	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		chk(32'(req_p), 32'h1);
		rd(8'h90, 32'h0000_0701);
		rd(8'h94, 32'h2040_0000);
		rd(8'h88, 32'h0000_003c);
		rd(8'h9c, 32'h0);
		rd(8'h80, 32'h0);
		wb(1'b1, 8'h94, 32'hffff_ffff, 4'h2);
		rd(8'h94, 32'h2040_ff00);
		chk(flag_style_o, 32'h2040_ff00);
		in_load <= 8'h3c;
		cmd_load <= 8'h5a;
		out_load <= 8'ha5;
		op_code <= 8'h12;
		op_arg <= 24'h345678;
		wb(1'b1, 8'h98, 32'hffff_ffff);
		rd(8'h98, 32'h005a_a53c);
		out_load <= 8'h00;
		in_load <= 8'h00;
		wb(1'b1, 8'h90, 32'h0000_0705);
		repeat (10) @(posedge clk_i);
		chk(32'(req_w), 32'h0);
		foreach (lens[i])
		begin
			wb(1'b1, 8'h90, {19'h0, 5'(lens[i]), 8'h07});
			in_load <= 8'h3b;
			wait_req(1'b1);
			repeat (10) @(posedge clk_i);
			chk(32'(req_w), 32'h1);
			in_load <= 8'h3c;
			count_stop(lens[i]);
		end
		wb(1'b1, 8'h88, 32'h0000_0010);
		in_load <= 8'h3b;
		repeat (10) @(posedge clk_i);
		chk(32'(req_w), 32'h0);
		in_load <= 8'h0f;
		wait_req(1'b1);
		in_load <= 8'h10;
		count_stop(31);
		wb(1'b1, 8'h90, 32'h0000_0302);
		out_load <= 8'h01;
		wait_req(1'b1);
		wait_req(1'b0);
		out_load <= 8'h00;
		repeat (50) @(posedge clk_i);
		rd(8'ha0, 32'h3);
		chk(32'(irq_o), 32'h0);
		wb(1'b1, 8'ha4, 32'h1);
		repeat (3) @(posedge clk_i);
		chk({irq_o, irq_w}, 32'h3);
		wb(1'b1, 8'ha0, 32'h1);
		repeat (3) @(posedge clk_i);
		chk(32'(irq_o), 32'h0);
		rd(8'ha0, 32'h2);
		wb(1'b1, 8'ha0, 32'h2);
		rd(8'ha0, 32'h0);
		wb(1'b1, 8'h90, 32'h0000_0708);
		repeat (3) @(posedge clk_i);
		chk({req_w, stp_w, irq_w}, 32'h7);
		wb(1'b1, 8'h90, 32'h0000_0710);
		repeat (3) @(posedge clk_i);
		chk({req_p, stp_p, irq_p}, 32'h15);
		in_load <= 8'h00;
		wb(1'b1, 8'h90, 32'h0000_0717);
		wait_req(1'b1);
		chk(32'(req_p), 32'h0);
		stop_test();
	end

	initial
	begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		stop_test();
	end
endmodule : testbench
